//--- logic/bdmd_pkg.sv
/*
 Package for the banked data memory decoder: map offsets, field positions,
 reset values and address ranges.
 Assumes nothing of its surroundings.
*/
package bdmd_pkg;
   localparam int BDMD_BANK_SIZE = 128;
   localparam logic [6:0] BDMD_OFS_INDIRECT = 7'h00;
   localparam logic [6:0] BDMD_OFS_PCL = 7'h02;
   localparam logic [6:0] BDMD_OFS_STATUS = 7'h03;
   localparam logic [6:0] BDMD_OFS_POINTER = 7'h04;
   localparam logic [6:0] BDMD_OFS_PCLATH = 7'h0a;
   localparam logic [6:0] BDMD_OFS_INTCTL = 7'h0b;
   localparam logic [6:0] BDMD_OFS_COMMON = 7'h70;
   localparam int BDMD_STAT_IRP = 7;
   localparam int BDMD_STAT_BANK_HI = 6;
   localparam int BDMD_STAT_BANK_LO = 5;
   localparam logic [7:0] BDMD_STATUS_RST = 8'h18;
   localparam logic [7:0] BDMD_POINTER_RST = 8'h00;
   localparam logic [7:0] BDMD_PCL_RST = 8'h00;
   localparam logic [7:0] BDMD_PCLATH_RST = 8'h00;
   localparam logic [7:0] BDMD_INTCTL_RST = 8'h00;
   localparam logic [7:0] BDMD_PCLATH_MASK = 8'h1f;
   localparam logic [8:0] BDMD_GPR0_LO = 9'h020;
   localparam logic [8:0] BDMD_GPR0_HI = 9'h07f;
   localparam logic [8:0] BDMD_GPR1_LO = 9'h0a0;
   localparam logic [8:0] BDMD_GPR1_HI = 9'h0ef;
   localparam logic [8:0] BDMD_GPR2_LO = 9'h120;
   localparam logic [8:0] BDMD_GPR2_HI = 9'h16f;
   // Bank 1 and bank 2 storage follow the 96 bank 0 bytes, so no two windows share a byte
   localparam logic [8:0] BDMD_RAM1_BASE = 9'h060;
   localparam logic [8:0] BDMD_RAM2_BASE = 9'h0b0;
   localparam int BDMD_RAM_DEPTH = 256;
   typedef enum logic [2:0] {
      BDMD_T_NONE,
      BDMD_T_INDIRECT,
      BDMD_T_CORE,
      BDMD_T_RAM,
      BDMD_T_PERIPH
   } bdmd_target_t;
endpackage

//--- logic/bdmd_decode_if.sv
/*
 Interface carrying a decoded data memory address between the top and the
 decode module.
 Assumes one clock domain; the decode is purely combinational.
*/
`timescale 1ns/10ps
`default_nettype none
interface bdmd_decode_if;
   import bdmd_pkg::*;
   logic [8:0] addr;
   bdmd_target_t target;
   logic [7:0] ram_index;
   logic [6:0] core_ofs;
   modport requester (output addr, input target, ram_index, core_ofs);
   modport decoder (input addr, output target, ram_index, core_ofs);
endinterface
`default_nettype wire

//--- logic/bdmd_decode.sv
/*
 Combinational map decode: classifies a 9-bit data memory address.
 Assumes the address is already formed from bank bits and offset.
*/
`timescale 1ns/10ps
`default_nettype none
module bdmd_decode (
   // Decode request and result
   bdmd_decode_if.decoder dec
);
   import bdmd_pkg::*;

   function automatic logic in_range(input logic [8:0] a, input logic [8:0] lo,
                                     input logic [8:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   logic [6:0] ofs;
   logic [1:0] bank;
   logic [8:0] rel;

   always_comb begin
      ofs = dec.addr[6:0];
      bank = dec.addr[8:7];
      rel = 9'h000;
      dec.target = BDMD_T_NONE;
      dec.ram_index = 8'h00;
      dec.core_ofs = ofs;
      if (ofs == BDMD_OFS_INDIRECT) begin
         dec.target = BDMD_T_INDIRECT;
      end else if (ofs == BDMD_OFS_PCL || ofs == BDMD_OFS_STATUS ||
                   ofs == BDMD_OFS_POINTER || ofs == BDMD_OFS_PCLATH ||
                   ofs == BDMD_OFS_INTCTL) begin
         dec.target = BDMD_T_CORE;
      end else if (ofs >= BDMD_OFS_COMMON) begin
         dec.target = BDMD_T_RAM;
         rel = {2'b00, ofs} - BDMD_GPR0_LO;
         dec.ram_index = rel[7:0];
      end else if (in_range(dec.addr, BDMD_GPR0_LO, BDMD_GPR0_HI)) begin
         dec.target = BDMD_T_RAM;
         rel = dec.addr - BDMD_GPR0_LO;
         dec.ram_index = rel[7:0];
      end else if (in_range(dec.addr, BDMD_GPR1_LO, BDMD_GPR1_HI)) begin
         dec.target = BDMD_T_RAM;
         rel = dec.addr - BDMD_GPR1_LO + BDMD_RAM1_BASE;
         dec.ram_index = rel[7:0];
      end else if (in_range(dec.addr, BDMD_GPR2_LO, BDMD_GPR2_HI)) begin
         dec.target = BDMD_T_RAM;
         rel = dec.addr - BDMD_GPR2_LO + BDMD_RAM2_BASE;
         dec.ram_index = rel[7:0];
      end else if (ofs < BDMD_GPR0_LO[6:0] && bank != 2'b11) begin
         // Peripheral slots of the special function area, served outside
         dec.target = BDMD_T_PERIPH;
      end
   end
endmodule
`default_nettype wire

//--- logic/bdmd_top.sv
/*
 Banked data memory decoder: bank selection, direct and indirect addressing,
 mirrored core registers, general purpose RAM and zero reads elsewhere.
 Assumes the core presents one access per cycle on the core clock.
*/
// Notes on behaviour
// - Status bits 6:5 pick the bank for direct access, 00 bank 0 to 11 bank 3.
// - Each bank holds 128 locations, offsets 00h to 7Fh.
// - Special function registers sit at the bottom of every bank from offset 00h.
// - RAM spans 20h-7Fh in bank 0, A0h-EFh in bank 1 and 120h-16Fh in bank 2.
// - Every location is reachable directly or through the pointer register.
// - Offset 00h of each bank is the indirect port and holds no storage.
// - Status, pointer, PC low, PC latch and interrupt control are shared by all banks.
// - Reads of unimplemented locations return zero.
`timescale 1ns/10ps
`default_nettype none
module bdmd_top #(
   parameter int RAM_DEPTH = bdmd_pkg::BDMD_RAM_DEPTH
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Core access request
   input wire logic i_rd,
   input wire logic i_wr,
   input wire logic [6:0] i_dir_ofs,
   input wire logic [7:0] i_wdata,
   // Core side updates of core registers
   input wire logic i_pcl_ld,
   input wire logic [7:0] i_pcl,
   input wire logic i_flags_ld,
   input wire logic [4:0] i_flags,
   input wire logic [7:0] i_intctl_set,
   // Read answer
   output logic o_rvalid,
   output logic [7:0] o_rdata,
   // Peripheral slot access
   output logic o_per_rd,
   output logic o_per_wr,
   output logic [8:0] o_per_addr,
   output logic [7:0] o_per_wdata,
   input wire logic [7:0] i_per_rdata,
   // Core register view
   output logic [7:0] o_status,
   output logic [7:0] o_pointer,
   output logic [7:0] o_pcl,
   output logic [7:0] o_pclath,
   output logic [7:0] o_intctl
);
   import bdmd_pkg::*;

   logic [7:0] ram [RAM_DEPTH];
   logic [7:0] status_q;
   logic [7:0] pointer_q;
   logic [7:0] pcl_q;
   logic [7:0] pclath_q;
   logic [7:0] intctl_q;
   logic [8:0] dir_addr;
   logic [8:0] ind_addr;
   logic [8:0] eff_addr;
   logic [7:0] rd_d;
   logic wr_core;
   logic wr_ram;
   logic wr_status;
   logic wr_pointer;
   logic wr_pcl;
   logic wr_pclath;
   logic wr_intctl;

   // Write strobe of one core register; the offset alone picks it in every bank
   function automatic logic core_hit(input logic wr, input logic [6:0] ofs,
                                     input logic [6:0] want);
      core_hit = wr && ofs == want;
   endfunction

   bdmd_decode_if dec_if ();

   bdmd_decode u_decode (
      .dec(dec_if)
   );

   // Bank bits pick the bank of a direct access
   assign dir_addr = {status_q[BDMD_STAT_BANK_HI], status_q[BDMD_STAT_BANK_LO],
                      i_dir_ofs};
   assign ind_addr = {status_q[BDMD_STAT_IRP], pointer_q};
   // The indirect port steers the access through the pointer
   assign eff_addr = (i_dir_ofs == BDMD_OFS_INDIRECT) ? ind_addr : dir_addr;
   assign dec_if.addr = eff_addr;

   // A nested indirect access lands on the port again and does nothing
   assign wr_core = i_wr && dec_if.target == BDMD_T_CORE;
   assign wr_ram = i_wr && dec_if.target == BDMD_T_RAM;
   // A core write wins over the core's own flag and counter loads
   assign wr_status = core_hit(wr_core, dec_if.core_ofs, BDMD_OFS_STATUS);
   assign wr_pointer = core_hit(wr_core, dec_if.core_ofs, BDMD_OFS_POINTER);
   assign wr_pcl = core_hit(wr_core, dec_if.core_ofs, BDMD_OFS_PCL);
   assign wr_pclath = core_hit(wr_core, dec_if.core_ofs, BDMD_OFS_PCLATH);
   assign wr_intctl = core_hit(wr_core, dec_if.core_ofs, BDMD_OFS_INTCTL);

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         status_q <= BDMD_STATUS_RST;
      end else if (wr_status) begin
         status_q <= i_wdata;
      end else if (i_flags_ld) begin
         status_q[4:0] <= i_flags;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pointer_q <= BDMD_POINTER_RST;
      end else if (wr_pointer) begin
         pointer_q <= i_wdata;
      end
   end

   // Only the low five bits of the latch exist; the rest read as zero
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pclath_q <= BDMD_PCLATH_RST;
      end else if (wr_pclath) begin
         pclath_q <= i_wdata & BDMD_PCLATH_MASK;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pcl_q <= BDMD_PCL_RST;
      end else if (wr_pcl) begin
         pcl_q <= i_wdata;
      end else if (i_pcl_ld) begin
         pcl_q <= i_pcl;
      end
   end

   // Hardware set wins over a software write of the same bit
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         intctl_q <= BDMD_INTCTL_RST;
      end else if (wr_intctl) begin
         intctl_q <= i_wdata | i_intctl_set;
      end else begin
         intctl_q <= intctl_q | i_intctl_set;
      end
   end

   // RAM has no reset; its contents are unknown until written
   always_ff @(posedge i_clk) begin
      if (wr_ram) begin
         ram[dec_if.ram_index] <= i_wdata;
      end
   end

   always_comb begin
      case (dec_if.target)
         BDMD_T_CORE: begin
            case (dec_if.core_ofs)
               BDMD_OFS_PCL: rd_d = pcl_q;
               BDMD_OFS_STATUS: rd_d = status_q;
               BDMD_OFS_POINTER: rd_d = pointer_q;
               BDMD_OFS_PCLATH: rd_d = pclath_q;
               BDMD_OFS_INTCTL: rd_d = intctl_q;
               default: rd_d = 8'h00;
            endcase
         end
         BDMD_T_RAM: rd_d = ram[dec_if.ram_index];
         BDMD_T_PERIPH: rd_d = 8'h00;
         default: rd_d = 8'h00;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rvalid <= 1'b0;
      end else begin
         o_rvalid <= i_rd;
      end
   end

   // Data is zero outside a read answer so nothing stale reaches the core
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= 8'h00;
      end else begin
         o_rdata <= i_rd ? rd_d : 8'h00;
      end
   end

   // Strobes toward the peripheral slots outside this block
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_per_rd <= 1'b0;
         o_per_wr <= 1'b0;
      end else begin
         o_per_rd <= i_rd && dec_if.target == BDMD_T_PERIPH;
         o_per_wr <= i_wr && dec_if.target == BDMD_T_PERIPH;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_per_addr <= 9'h000;
         o_per_wdata <= 8'h00;
      end else begin
         o_per_addr <= eff_addr;
         o_per_wdata <= i_wdata;
      end
   end

   // Core register view straight from the registers
   assign o_status = status_q;
   assign o_pointer = pointer_q;
   assign o_pcl = pcl_q;
   assign o_pclath = pclath_q;
   assign o_intctl = intctl_q;

   // Peripheral read data is not returned; those slots read as zero here
   logic unused_per;
   assign unused_per = ^i_per_rdata;
endmodule
`default_nettype wire

//--- verif/bdmd_props.sv
/* Checker on the decoder top ports.
   Assumes one clock domain; bound to bdmd_top after the module. */
`timescale 1ns/10ps
`default_nettype none
module bdmd_props (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // Core access
   input wire logic i_rd,
   input wire logic i_wr,
   input wire logic [6:0] i_dir_ofs,
   input wire logic [7:0] i_wdata,
   // Answers and core registers
   input wire logic o_rvalid,
   input wire logic [7:0] o_rdata,
   input wire logic [7:0] o_status,
   input wire logic [7:0] o_pointer,
   input wire logic [7:0] o_pclath
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   property p_rvalid; i_rd |=> o_rvalid; endproperty
   a_rvalid: assert property (p_rvalid) else $error("read unanswered");
   property p_idle; !i_rd |=> o_rdata == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("data without read");
   property p_b3; i_rd && !i_wr && o_status[6:5] == 2'h3 && i_dir_ofs inside {[7'h0c:7'h6f]}
      |=> o_rdata == 8'h00; endproperty
   a_b3: assert property (p_b3) else $error("bank 3 hole not zero");
   property p_st; i_rd && !i_wr && i_dir_ofs == 7'h03 |=> o_rdata == $past(o_status); endproperty
   a_st: assert property (p_st) else $error("status read wrong");
   property p_pt; i_rd && !i_wr && i_dir_ofs == 7'h04 |=> o_rdata == $past(o_pointer); endproperty
   a_pt: assert property (p_pt) else $error("pointer read wrong");
   property p_bank; i_wr && i_dir_ofs == 7'h03 |=> o_status[7:5] == $past(i_wdata[7:5]); endproperty
   a_bank: assert property (p_bank) else $error("bank bits not written");
   property p_pclath; i_wr && i_dir_ofs == 7'h0a |=> o_pclath == ($past(i_wdata) & 8'h1f); endproperty
   a_pclath: assert property (p_pclath) else $error("latch write wrong");
   property p_port; i_wr && i_dir_ofs == 7'h00 && o_pointer[6:0] == 7'h00
      |=> $stable(o_pointer) && $stable(o_status[7:5]); endproperty
   a_port: assert property (p_port) else $error("port has storage");
   c_b3: cover property (i_rd && o_status[6:5] == 2'h3);
   c_ind: cover property (i_wr && i_dir_ofs == 7'h00);
   c_irp: cover property (i_wr && o_status[7]);
endmodule
bind bdmd_top bdmd_props chk_u (.i_clk, .i_rst_n, .i_rd, .i_wr, .i_dir_ofs, .i_wdata, .o_rvalid,
   .o_rdata, .o_status, .o_pointer, .o_pclath);
`default_nettype wire

//--- verif/bdmd_core_model.sv
/* Core datapath model: issues direct accesses and core register loads.
   Assumes reads are answered one cycle after the request edge. */
`timescale 1ns/10ps
`default_nettype none
module bdmd_core_model (
   // Clock and answer
   input wire logic i_clk,
   input wire logic i_rvalid,
   input wire logic [7:0] i_rdata,
   // Requests
   output logic o_rd,
   output logic o_wr,
   output logic [6:0] o_ofs,
   output logic [7:0] o_wdata,
   // Core register loads
   output logic o_pcl_ld,
   output logic [7:0] o_pcl,
   output logic o_flags_ld,
   output logic [4:0] o_flags,
   output logic [7:0] o_intctl_set
);
   initial begin
      {o_rd, o_wr, o_pcl_ld, o_flags_ld, o_ofs, o_wdata, o_pcl, o_flags, o_intctl_set} = '0;
   end
   task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d,
      output logic [7:0] q);
      @(posedge i_clk);
      o_rd <= !w;
      o_wr <= w;
      o_ofs <= a;
      o_wdata <= d;
      @(posedge i_clk);
      o_rd <= 1'b0;
      o_wr <= 1'b0;
      // Stale address and data are inverted so they are never taken as live
      o_ofs <= ~a;
      o_wdata <= ~d;
      @(posedge i_clk);
      q = i_rvalid ? i_rdata : 8'hxx;
   endtask
   task automatic side(input logic [7:0] p, input logic [4:0] f, input logic [7:0] s);
      @(posedge i_clk);
      {o_pcl_ld, o_pcl, o_flags_ld, o_flags, o_intctl_set} <= {1'b1, p, 1'b1, f, s};
      @(posedge i_clk);
      {o_pcl_ld, o_flags_ld, o_intctl_set} <= '0;
      @(posedge i_clk);
   endtask
endmodule
`default_nettype wire

//--- verif/testbench.sv
/* Self-checking bench for the data memory decoder.
   Assumes the core model drives requests and the checker is bound. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
   import bdmd_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic rd, wr, pcl_ld, flags_ld, rvalid;
   logic [6:0] ofs;
   logic [7:0] wdata, pcl, iset, rdata, status, pointer, pcl_q, pclath, intctl;
   logic [4:0] flags;
   logic per_rd, per_wr;
   logic [8:0] per_addr;
   logic [7:0] per_wdata;
   int miscompares = 0;
   int samples_checked = 0;
   int cycles = 0;
   initial begin
      forever #50 i_clk = ~i_clk;
   end
   bdmd_core_model core_u (.i_clk, .i_rvalid(rvalid), .i_rdata(rdata), .o_rd(rd), .o_wr(wr),
      .o_ofs(ofs), .o_wdata(wdata), .o_pcl_ld(pcl_ld), .o_pcl(pcl), .o_flags_ld(flags_ld),
      .o_flags(flags), .o_intctl_set(iset));
   bdmd_top dut_u (.i_clk, .i_rst_n, .i_rd(rd), .i_wr(wr), .i_dir_ofs(ofs), .i_wdata(wdata),
      .i_pcl_ld(pcl_ld), .i_pcl(pcl), .i_flags_ld(flags_ld), .i_flags(flags),
      .i_intctl_set(iset), .o_rvalid(rvalid), .o_rdata(rdata), .o_per_rd(per_rd),
      .o_per_wr(per_wr), .o_per_addr(per_addr), .o_per_wdata(per_wdata),
      .i_per_rdata(8'ha5), .o_status(status),
      .o_pointer(pointer), .o_pcl(pcl_q), .o_pclath(pclath), .o_intctl(intctl));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t saw %h want %h", $time, seen, exp);
      end
   endtask
   task automatic wr_b(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] q;
      core_u.xfer(1'b1, a, d, q);
   endtask
   task automatic rd_b(input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] q;
      core_u.xfer(1'b0, a, 8'h00, q);
      chk(q, exp);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (20) @(posedge i_clk);
      i_rst_n <= 1'b1;
      chk(status, BDMD_STATUS_RST);
      chk(pointer, BDMD_POINTER_RST);
      for (int b = 0; b < 3; b++) begin
         wr_b(BDMD_OFS_STATUS, {1'b0, 2'(b), 5'h00});
         wr_b(7'h20, 8'h10 + 8'(b));
         wr_b(7'h6f, 8'h20 + 8'(b));
      end
      wr_b(BDMD_OFS_STATUS, 8'h60);
      wr_b(7'h20, 8'hee);
      rd_b(7'h20, 8'h00);
      chk({7'h00, per_rd}, 8'h00);
      wr_b(7'h70, 8'h5a);
      for (int b = 0; b < 3; b++) begin
         wr_b(BDMD_OFS_STATUS, {1'b0, 2'(b), 5'h00});
         rd_b(7'h20, 8'h10 + 8'(b));
         rd_b(7'h6f, 8'h20 + 8'(b));
         rd_b(7'h70, 8'h5a);
      end
      $display("bank test done");
      wr_b(BDMD_OFS_PCLATH, 8'hff);
      wr_b(BDMD_OFS_STATUS, 8'h20);
      rd_b(BDMD_OFS_PCLATH, 8'h1f);
      wr_b(BDMD_OFS_POINTER, 8'h30);
      wr_b(BDMD_OFS_INDIRECT, 8'h77);
      wr_b(BDMD_OFS_STATUS, 8'h00);
      rd_b(7'h30, 8'h77);
      rd_b(BDMD_OFS_POINTER, 8'h30);
      wr_b(BDMD_OFS_STATUS, 8'h80);
      wr_b(BDMD_OFS_POINTER, 8'h25);
      wr_b(BDMD_OFS_INDIRECT, 8'h99);
      wr_b(BDMD_OFS_STATUS, 8'h40);
      rd_b(7'h25, 8'h99);
      $display("indirect test done");
      wr_b(BDMD_OFS_STATUS, 8'h00);
      wr_b(BDMD_OFS_POINTER, 8'h80);
      wr_b(BDMD_OFS_INDIRECT, 8'h11);
      rd_b(BDMD_OFS_POINTER, 8'h80);
      chk({5'h00, status[7:5]}, 8'h00);
      rd_b(7'h01, 8'h00);
      chk({7'h00, per_rd}, 8'h01);
      chk(per_addr[7:0], 8'h01);
      wr_b(BDMD_OFS_STATUS, 8'h40);
      wr_b(7'h06, 8'hc3);
      chk({6'h00, per_wr, per_addr[8]}, 8'h03);
      chk(per_wdata, 8'hc3);
      wr_b(BDMD_OFS_STATUS, 8'h00);
      core_u.side(8'h3c, 5'h05, 8'h01);
      chk(pcl_q, 8'h3c);
      chk({3'h0, status[4:0]}, 8'h05);
      chk(intctl, 8'h01);
      rd_b(BDMD_OFS_PCL, 8'h3c);
      $display("core register test done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
